/* bsc_pkg.sv */
// constants, register map and helpers for the breaker synchronism check
package bsc_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_LEVEL    = 8'h04;
	localparam logic [7:0] OFF_STAGE1   = 8'h08;
	localparam logic [7:0] OFF_STAGE2   = 8'h0C;
	localparam logic [7:0] OFF_VBAND    = 8'h10;
	localparam logic [7:0] OFF_DIFF     = 8'h14;
	localparam logic [7:0] OFF_TIMER    = 8'h18;
	localparam logic [7:0] OFF_FLAGS    = 8'h1C;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h24;

	// ==========================================================
	// control field positions
	localparam int CTRL_SYS_EN   = 0;
	localparam int CTRL_ST1_EN   = 1;
	localparam int CTRL_ST2_EN   = 2;
	localparam int CTRL_SPLIT_EN = 3;
	localparam int CTRL_SIDE     = 4;
	localparam int CTRL_SEL_LO   = 5;
	localparam int CTRL_VBLK_LO  = 8;
	localparam int CTRL_SLIP1_LO = 11;
	localparam int CTRL_SLIP2_LO = 13;
	localparam logic [31:0] CTRL_MASK = 32'h0000_7FFF;

	// volt blocking bits inside the 3-bit field
	localparam int VBLK_UV   = 0;
	localparam int VBLK_OV   = 1;
	localparam int VBLK_DIFF = 2;

	// slip control encodings
	localparam logic [1:0] SLIP_NONE  = 2'h0;
	localparam logic [1:0] SLIP_FREQ  = 2'h1;
	localparam logic [1:0] SLIP_TIMER = 2'h2;
	localparam logic [1:0] SLIP_BOTH  = 2'h3;

	// check input connection choices
	localparam logic [2:0] SEL_AN = 3'h0;
	localparam logic [2:0] SEL_CA = 3'h5;

	// ==========================================================
	// flag bus bit positions
	localparam int FLG_LINE_LIVE = 0;
	localparam int FLG_LINE_DEAD = 1;
	localparam int FLG_BUS_LIVE  = 2;
	localparam int FLG_BUS_DEAD  = 3;
	localparam int FLG_CS1_OK    = 4;
	localparam int FLG_CS2_OK    = 5;
	localparam int FLG_SPLIT     = 6;
	localparam int FLG_INACTIVE  = 7;
	localparam int NUM_FLAGS     = 8;

	// ==========================================================
	// reset values (volts x10, degrees x10, mHz, updates)
	localparam logic [31:0] RST_CTRL   = 32'h0000_290F;
	localparam logic [31:0] RST_LEVEL  = 32'h0082_0140;
	localparam logic [31:0] RST_STAGE1 = 32'h0032_00C8;
	localparam logic [31:0] RST_STAGE2 = 32'h0032_00C8;
	localparam logic [31:0] RST_VBAND  = 32'h0514_021C;
	localparam logic [31:0] RST_DIFF   = 32'h04B0_0041;
	localparam logic [31:0] RST_TIMER  = 32'h0032_0032;

	// ==========================================================
	// helpers
	function automatic logic [15:0] abs16(input logic [15:0] v);
		abs16 = v[15] ? 16'(~v + 16'h0001) : v;
	endfunction

	function automatic logic [15:0] absdiff16(input logic [15:0] a, input logic [15:0] b);
		absdiff16 = (a >= b) ? 16'(a - b) : 16'(b - a);
	endfunction

endpackage

/* bsc_meas_if.sv */
// measured quantities shared by the top and the check stages
`timescale 1ns/1ns
interface bsc_meas_if;
	logic [15:0] line_mag;
	logic [15:0] bus_mag;
	logic [15:0] angle_mag;
	logic [15:0] slip;
	logic        angle_dec;
	logic        both_live;
	logic        update;

	modport src (
		output line_mag,
		output bus_mag,
		output angle_mag,
		output slip,
		output angle_dec,
		output both_live,
		output update
	);

	modport dst (
		input line_mag,
		input bus_mag,
		input angle_mag,
		input slip,
		input angle_dec,
		input both_live,
		input update
	);
endinterface

/* bsc_level_classify.sv */
// live and dead classification of one voltage magnitude
`timescale 1ns/1ns
module bsc_level_classify #(
	parameter int W = 16
) (
	input  wire logic [W-1:0] mag,
	input  wire logic [W-1:0] live_thr,
	input  wire logic [W-1:0] dead_thr,
	output logic              live,
	output logic              dead
);
	// ==========================================================
	// compare
	// live is not-less-than, dead is strictly below; a band between
	// the two thresholds leaves both flags low
	assign live = (mag >= live_thr);
	assign dead = (mag < dead_thr);
endmodule

/* bsc_sync_stage.sv */
// one synchronism check stage with its slip timer
`timescale 1ns/1ns
module bsc_sync_stage #(
	parameter bit NEED_DECREASE = 1'b0
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	bsc_meas_if.dst          meas,
	input  wire logic        enable,
	input  wire logic [15:0] angle_limit,
	input  wire logic [15:0] slip_limit,
	input  wire logic [1:0]  slip_ctrl,
	input  wire logic [15:0] slip_time,
	input  wire logic [2:0]  vblock,
	input  wire logic [15:0] uv_thr,
	input  wire logic [15:0] ov_thr,
	input  wire logic [15:0] diff_thr,
	output logic             ok
);
	logic [15:0] hold_q;
	logic        cond;
	logic        freq_ok;
	logic        v_ok;
	logic        time_ok;
	logic        use_timer;

	// ==========================================================
	// conditions
	assign freq_ok = !(slip_ctrl == bsc_pkg::SLIP_FREQ || slip_ctrl == bsc_pkg::SLIP_BOTH)
		|| (meas.slip < slip_limit);
	assign v_ok = (!vblock[bsc_pkg::VBLK_OV]
			|| (meas.line_mag < ov_thr && meas.bus_mag < ov_thr))
		&& (!vblock[bsc_pkg::VBLK_UV]
			|| (meas.line_mag > uv_thr && meas.bus_mag > uv_thr))
		&& (!vblock[bsc_pkg::VBLK_DIFF]
			|| (bsc_pkg::absdiff16(meas.line_mag, meas.bus_mag) < diff_thr));
	assign cond = enable && meas.both_live && (meas.angle_mag < angle_limit)
		&& (!NEED_DECREASE || meas.angle_dec) && freq_ok && v_ok;
	assign use_timer = (slip_ctrl == bsc_pkg::SLIP_TIMER || slip_ctrl == bsc_pkg::SLIP_BOTH);
	// this update counts toward the hold time, so a time of 1 passes at once
	assign time_ok = !use_timer || (17'(hold_q) + 17'h00001 >= 17'(slip_time));
	assign ok = cond && time_ok;

	// ==========================================================
	// hold counter, saturating, advanced once per update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q <= 16'h0000;
		end else if (meas.update) begin
			if (!cond) begin
				hold_q <= 16'h0000;
			end else if (hold_q != 16'hFFFF) begin
				hold_q <= 16'(hold_q + 16'h0001);
			end
		end
	end
endmodule

/* bsc_top.sv */
// breaker synchronism check: apb registers, selection, flags, interrupt
`timescale 1ns/1ns
module bsc_top #(
	parameter int AW = 8
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic [AW-1:0] paddr,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          meas_update,
	input  wire logic [95:0]   main_mag,
	input  wire logic [95:0]   main_angle,
	input  wire logic [15:0]   check_mag,
	input  wire logic [15:0]   slip_freq,
	input  wire logic          cs1_user_enable,
	input  wire logic          cs2_user_enable,
	input  wire logic          split_user_enable,
	output logic [7:0]         internal_flag_bus,
	output logic               reclose_cs1_ok,
	output logic               reclose_cs2_ok,
	output logic               irq
);
	// ==========================================================
	// register state
	logic [31:0] ctrl_q;
	logic [31:0] level_q;
	logic [31:0] stage1_q;
	logic [31:0] stage2_q;
	logic [31:0] vband_q;
	logic [31:0] diff_q;
	logic [31:0] timer_q;
	logic [bsc_pkg::NUM_FLAGS-1:0] irq_stat_q;
	logic [bsc_pkg::NUM_FLAGS-1:0] irq_mask_q;
	logic [bsc_pkg::NUM_FLAGS-1:0] flags_q;
	logic [bsc_pkg::NUM_FLAGS-1:0] flags_prev_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        irq_q;
	logic [15:0] angle_prev_q;

	// ==========================================================
	// decoded controls
	logic        sys_en;
	logic        st1_en;
	logic        st2_en;
	logic        split_en;
	logic        side_bus;
	logic [2:0]  sel;
	logic [2:0]  vblock;
	logic [1:0]  slip1;
	logic [1:0]  slip2;

	assign sys_en   = ctrl_q[bsc_pkg::CTRL_SYS_EN];
	assign st1_en   = ctrl_q[bsc_pkg::CTRL_ST1_EN];
	assign st2_en   = ctrl_q[bsc_pkg::CTRL_ST2_EN];
	assign split_en = ctrl_q[bsc_pkg::CTRL_SPLIT_EN];
	assign side_bus = ctrl_q[bsc_pkg::CTRL_SIDE];
	assign sel      = ctrl_q[bsc_pkg::CTRL_SEL_LO +: 3];
	assign vblock   = ctrl_q[bsc_pkg::CTRL_VBLK_LO +: 3];
	assign slip1    = ctrl_q[bsc_pkg::CTRL_SLIP1_LO +: 2];
	assign slip2    = ctrl_q[bsc_pkg::CTRL_SLIP2_LO +: 2];

	// ==========================================================
	// apb decode
	logic        acc_first;
	logic        wr_commit;
	logic        addr_hit;
	logic [31:0] rd_word;
	logic [7:0]  addr8;

	assign addr8     = 8'(paddr);
	assign acc_first = psel && penable && !pready_q;
	// writes land on the edge where the master sees pready high
	assign wr_commit = psel && penable && pready_q && pwrite && !pslverr_q;

	always_comb begin
		addr_hit = 1'b1;
		rd_word  = 32'h0000_0000;
		case (addr8)
			bsc_pkg::OFF_CTRL:     rd_word = ctrl_q;
			bsc_pkg::OFF_LEVEL:    rd_word = level_q;
			bsc_pkg::OFF_STAGE1:   rd_word = stage1_q;
			bsc_pkg::OFF_STAGE2:   rd_word = stage2_q;
			bsc_pkg::OFF_VBAND:    rd_word = vband_q;
			bsc_pkg::OFF_DIFF:     rd_word = diff_q;
			bsc_pkg::OFF_TIMER:    rd_word = timer_q;
			bsc_pkg::OFF_FLAGS:    rd_word = {24'h00_0000, flags_q};
			bsc_pkg::OFF_IRQ_STAT: rd_word = {24'h00_0000, irq_stat_q};
			bsc_pkg::OFF_IRQ_MASK: rd_word = {24'h00_0000, irq_mask_q};
			default:               addr_hit = 1'b0;
		endcase
	end

	// one wait state: answer flops load on the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (acc_first) begin
			pready_q  <= 1'b1;
			prdata_q  <= (!pwrite && addr_hit) ? rd_word : 32'h0000_0000;
			// flags register is read-only; a write to it is an error
			pslverr_q <= !addr_hit || (pwrite && addr8 == bsc_pkg::OFF_FLAGS);
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// ==========================================================
	// settings registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q   <= bsc_pkg::RST_CTRL;
			level_q  <= bsc_pkg::RST_LEVEL;
			stage1_q <= bsc_pkg::RST_STAGE1;
			stage2_q <= bsc_pkg::RST_STAGE2;
			vband_q  <= bsc_pkg::RST_VBAND;
			diff_q   <= bsc_pkg::RST_DIFF;
			timer_q  <= bsc_pkg::RST_TIMER;
		end else if (wr_commit) begin
			case (addr8)
				bsc_pkg::OFF_CTRL:   ctrl_q   <= pwdata & bsc_pkg::CTRL_MASK;
				bsc_pkg::OFF_LEVEL:  level_q  <= pwdata;
				bsc_pkg::OFF_STAGE1: stage1_q <= pwdata;
				bsc_pkg::OFF_STAGE2: stage2_q <= pwdata;
				bsc_pkg::OFF_VBAND:  vband_q  <= pwdata;
				bsc_pkg::OFF_DIFF:   diff_q   <= pwdata;
				bsc_pkg::OFF_TIMER:  timer_q  <= pwdata;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// input side and connection selection
	logic [15:0] sel_mag;
	logic [15:0] sel_angle;
	logic [2:0]  sel_safe;

	// out-of-range choices fall back to the first phase-to-neutral pair
	assign sel_safe  = (sel > bsc_pkg::SEL_CA) ? bsc_pkg::SEL_AN : sel;
	assign sel_mag   = main_mag[16*sel_safe +: 16];
	assign sel_angle = main_angle[16*sel_safe +: 16];

	bsc_meas_if meas ();

	assign meas.line_mag  = side_bus ? check_mag : sel_mag;
	assign meas.bus_mag   = side_bus ? sel_mag : check_mag;
	assign meas.angle_mag = bsc_pkg::abs16(sel_angle);
	assign meas.slip      = slip_freq;
	assign meas.update    = meas_update;
	// decreasing is judged against the previous update's angle
	assign meas.angle_dec = (meas.angle_mag < angle_prev_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			angle_prev_q <= 16'h0000;
		end else if (meas_update) begin
			angle_prev_q <= meas.angle_mag;
		end
	end

	// ==========================================================
	// live and dead classification
	logic line_live;
	logic line_dead;
	logic bus_live;
	logic bus_dead;

	bsc_level_classify #(.W(16)) u_line (
		.mag      (meas.line_mag),
		.live_thr (level_q[15:0]),
		.dead_thr (level_q[31:16]),
		.live     (line_live),
		.dead     (line_dead)
	);

	bsc_level_classify #(.W(16)) u_bus (
		.mag      (meas.bus_mag),
		.live_thr (level_q[15:0]),
		.dead_thr (level_q[31:16]),
		.live     (bus_live),
		.dead     (bus_dead)
	);

	assign meas.both_live = line_live && bus_live;

	// ==========================================================
	// synchronism stages
	logic cs1_ok;
	logic cs2_ok;

	bsc_sync_stage #(.NEED_DECREASE(1'b0)) u_stage1 (
		.pclk        (pclk),
		.presetn     (presetn),
		.meas        (meas),
		.enable      (sys_en && st1_en && cs1_user_enable),
		.angle_limit (stage1_q[15:0]),
		.slip_limit  (stage1_q[31:16]),
		.slip_ctrl   (slip1),
		.slip_time   (timer_q[15:0]),
		.vblock      (vblock),
		.uv_thr      (vband_q[15:0]),
		.ov_thr      (vband_q[31:16]),
		.diff_thr    (diff_q[15:0]),
		.ok          (cs1_ok)
	);

	bsc_sync_stage #(.NEED_DECREASE(1'b1)) u_stage2 (
		.pclk        (pclk),
		.presetn     (presetn),
		.meas        (meas),
		.enable      (sys_en && st2_en && cs2_user_enable),
		.angle_limit (stage2_q[15:0]),
		.slip_limit  (stage2_q[31:16]),
		.slip_ctrl   (slip2),
		.slip_time   (timer_q[31:16]),
		.vblock      (vblock),
		.uv_thr      (vband_q[15:0]),
		.ov_thr      (vband_q[31:16]),
		.diff_thr    (diff_q[15:0]),
		.ok          (cs2_ok)
	);

	// ==========================================================
	// system split
	logic split_now;

	assign split_now = split_en && split_user_enable && meas.both_live
		&& (meas.angle_mag > diff_q[31:16]);

	// ==========================================================
	// flag register, refreshed once per update
	logic [bsc_pkg::NUM_FLAGS-1:0] flags_d;

	always_comb begin
		flags_d = '0;
		flags_d[bsc_pkg::FLG_LINE_LIVE] = line_live;
		flags_d[bsc_pkg::FLG_LINE_DEAD] = line_dead;
		flags_d[bsc_pkg::FLG_BUS_LIVE]  = bus_live;
		flags_d[bsc_pkg::FLG_BUS_DEAD]  = bus_dead;
		flags_d[bsc_pkg::FLG_CS1_OK]    = cs1_ok;
		flags_d[bsc_pkg::FLG_CS2_OK]    = cs2_ok;
		flags_d[bsc_pkg::FLG_SPLIT]     = split_now;
	end

	// disabling takes effect at once, without waiting for an update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= '0;
		end else if (!sys_en) begin
			flags_q <= '0;
			flags_q[bsc_pkg::FLG_INACTIVE] <= 1'b1;
		end else if (meas_update) begin
			flags_q <= flags_d;
		end else begin
			flags_q[bsc_pkg::FLG_INACTIVE] <= 1'b0;
		end
	end

	// ==========================================================
	// interrupts: a rising flag sets a sticky bit, write one clears
	logic [bsc_pkg::NUM_FLAGS-1:0] rise;
	logic [bsc_pkg::NUM_FLAGS-1:0] w1c;

	assign rise = flags_q & ~flags_prev_q;
	assign w1c  = (wr_commit && addr8 == bsc_pkg::OFF_IRQ_STAT)
		? pwdata[bsc_pkg::NUM_FLAGS-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_prev_q <= '0;
			irq_stat_q   <= '0;
		end else begin
			flags_prev_q <= flags_q;
			// set beats clear so an edge in the clearing cycle survives
			irq_stat_q   <= (irq_stat_q & ~w1c) | rise;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= '0;
		end else if (wr_commit && addr8 == bsc_pkg::OFF_IRQ_MASK) begin
			irq_mask_q <= pwdata[bsc_pkg::NUM_FLAGS-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(((irq_stat_q & ~w1c) | rise) & irq_mask_q);
		end
	end

	// ==========================================================
	// outputs
	assign prdata            = prdata_q;
	assign pready            = pready_q;
	assign pslverr           = pslverr_q;
	assign internal_flag_bus = flags_q;
	assign reclose_cs1_ok    = flags_q[bsc_pkg::FLG_CS1_OK];
	assign reclose_cs2_ok    = flags_q[bsc_pkg::FLG_CS2_OK];
	assign irq               = irq_q;
endmodule

/* bsc_sva.sv */
// concurrent checks on the flag outputs of the synchronism check
`timescale 1ns/1ns
module bsc_sva (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       meas_update,
	input wire logic       cs1_user_enable,
	input wire logic       cs2_user_enable,
	input wire logic       split_user_enable,
	input wire logic [7:0] internal_flag_bus,
	input wire logic       reclose_cs1_ok,
	input wire logic       reclose_cs2_ok
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] f;
	assign f = internal_flag_bus;

	// ==========================================================
	// flag relations
	property p_cs1_live;
		f[4] |-> f[0] && f[2];
	endproperty
	a_cs1_live: assert property (p_cs1_live) else $error("stage one pass not live");
	property p_cs2_live;
		f[5] |-> f[0] && f[2];
	endproperty
	a_cs2_live: assert property (p_cs2_live) else $error("stage two pass not live");
	property p_split_live;
		f[6] |-> f[0] && f[2];
	endproperty
	a_split_live: assert property (p_split_live) else $error("split not live");
	property p_cs1_user;
		$rose(f[4]) |-> $past(meas_update) && $past(cs1_user_enable);
	endproperty
	a_cs1_user: assert property (p_cs1_user) else $error("stage one rose wrongly");
	property p_cs2_user;
		$rose(f[5]) |-> $past(meas_update) && $past(cs2_user_enable);
	endproperty
	a_cs2_user: assert property (p_cs2_user) else $error("stage two rose wrongly");
	property p_split_user;
		$rose(f[6]) |-> $past(meas_update) && $past(split_user_enable);
	endproperty
	a_split_user: assert property (p_split_user) else $error("split rose wrongly");
	// flags 0 to 6 may only move on an update or when the system check switches off
	property p_hold;
		!$past(meas_update) && !$rose(f[7]) |-> f[6:0] == $past(f[6:0]);
	endproperty
	a_hold: assert property (p_hold) else $error("flags moved without update");
	property p_inactive;
		f[7] |-> f[6:0] == 7'h00;
	endproperty
	a_inactive: assert property (p_inactive) else $error("flags set while inactive");
	property p_reclose;
		reclose_cs1_ok == f[4] && reclose_cs2_ok == f[5];
	endproperty
	a_reclose: assert property (p_reclose) else $error("reclose copy differs");

	c_cs1: cover property ($rose(f[4]));
	c_cs2: cover property ($rose(f[5]));
	c_split: cover property ($rose(f[6]));
	c_inact: cover property ($rose(f[7]));
endmodule

bind bsc_top bsc_sva u_sva (
	.pclk(pclk), .presetn(presetn), .meas_update(meas_update),
	.cs1_user_enable(cs1_user_enable), .cs2_user_enable(cs2_user_enable),
	.split_user_enable(split_user_enable), .internal_flag_bus(internal_flag_bus),
	.reclose_cs1_ok(reclose_cs1_ok), .reclose_cs2_ok(reclose_cs2_ok)
);

/* bsc_front.sv */
// measurement front end model: one update pulse per request
`timescale 1ns/1ns
module bsc_front (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        go,
	input  wire logic [95:0] mag_in,
	input  wire logic [95:0] ang_in,
	input  wire logic [15:0] chk_in,
	input  wire logic [15:0] slip_in,
	output logic             meas_update,
	output logic [95:0]      main_mag,
	output logic [95:0]      main_angle,
	output logic [15:0]      check_mag,
	output logic [15:0]      slip_freq
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meas_update <= 1'b0;
		end else begin
			meas_update <= go;
		end
	end
	// values only valid with the pulse; garbage between to catch late sampling
	always_ff @(posedge pclk) begin
		if (go) begin
			{main_mag, main_angle, check_mag, slip_freq} <= {mag_in, ang_in, chk_in, slip_in};
		end else begin
			{main_mag, main_angle, check_mag, slip_freq} <= ~{main_mag, main_angle, check_mag, slip_freq};
		end
	end
endmodule

/* testbench.sv */
// self-checking bench for the breaker synchronism check
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
	$display("Error %0t mismatch %h exp %h", $time, (a), (e)); end end
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        go, u1, u2, us, meas_update, irq, upd_seen;
	logic [7:0]  paddr, flags, y;
	logic [31:0] pwdata, prdata, ctrl_m, lfsr;
	logic [95:0] mag_in, ang_in, main_mag, main_angle;
	logic [15:0] chk_in, slip_in, check_mag, slip_freq, prev_an, tmr;
	logic [33:0] q_apb[$];
	logic [33:0] x;
	logic [7:0]  q_flg[$];
	int          n_errors, n_tests, i, h1, h2;
	logic [7:0]  offs [8] = '{bsc_pkg::OFF_CTRL, bsc_pkg::OFF_LEVEL, bsc_pkg::OFF_STAGE1,
		bsc_pkg::OFF_STAGE2, bsc_pkg::OFF_VBAND, bsc_pkg::OFF_DIFF, bsc_pkg::OFF_TIMER,
		bsc_pkg::OFF_IRQ_MASK};
	logic [31:0] rsts [8] = '{bsc_pkg::RST_CTRL, bsc_pkg::RST_LEVEL, bsc_pkg::RST_STAGE1,
		bsc_pkg::RST_STAGE2, bsc_pkg::RST_VBAND, bsc_pkg::RST_DIFF, bsc_pkg::RST_TIMER, 32'h0};
	logic [15:0] bnd [4] = '{bsc_pkg::RST_LEVEL[15:0], 16'(bsc_pkg::RST_LEVEL[15:0] - 1),
		bsc_pkg::RST_LEVEL[31:16], 16'(bsc_pkg::RST_LEVEL[31:16] - 1)};

	bsc_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .meas_update(meas_update),
		.main_mag(main_mag), .main_angle(main_angle), .check_mag(check_mag),
		.slip_freq(slip_freq), .cs1_user_enable(u1), .cs2_user_enable(u2),
		.split_user_enable(us), .internal_flag_bus(flags), .reclose_cs1_ok(),
		.reclose_cs2_ok(), .irq(irq));
	bsc_front u_front (.pclk(pclk), .presetn(presetn), .go(go), .mag_in(mag_in),
		.ang_in(ang_in), .chk_in(chk_in), .slip_in(slip_in), .meas_update(meas_update),
		.main_mag(main_mag), .main_angle(main_angle), .check_mag(check_mag),
		.slip_freq(slip_freq));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	function automatic logic [31:0] nxt(input logic [31:0] s);
		nxt = s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
	endfunction

	task tally_and_finish();
		if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// apb master: expectation noted, monitor compares
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, e,
		input logic er);
		int k;
		q_apb.push_back({w, e, er});
		psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin n_errors++; tally_and_finish(); end
		psel <= 1'b0; penable <= 1'b0; paddr <= ~a; pwdata <= ~d;
		@(posedge pclk);
	endtask

	// ==========================================================
	// one measurement update with its expected flags
	task automatic upd(input logic fx, input logic [15:0] fv);
		logic [95:0] mg, ag;
		logic [15:0] c, sl, a, m, ln, bs, an, lt, uv;
		logic [2:0]  s;
		logic        e1, e2, es, ll, bl, cm, c1, c2;
		for (int k = 0; k < 6; k++) begin
			lfsr = nxt(lfsr);
			mg[16*k+:16] = fx ? fv : {5'h00, lfsr[10:0]};
			ag[16*k+:16] = lfsr[20] ? 16'($signed(lfsr[19:8])) : 16'($signed(lfsr[16:8]));
		end
		lfsr = nxt(lfsr);
		c = fx ? fv : {5'h00, lfsr[10:0]};
		sl = {10'h000, lfsr[16:11]};
		{e1, e2, es} = {|lfsr[18:17], |lfsr[20:19], |lfsr[22:21]};
		s = (ctrl_m[7:5] > 3'h5) ? 3'h0 : ctrl_m[7:5];
		m = mg[16*s+:16];
		a = ag[16*s+:16];
		an = a[15] ? 16'(-a) : a;
		ln = ctrl_m[4] ? c : m;
		bs = ctrl_m[4] ? m : c;
		lt = bsc_pkg::RST_LEVEL[15:0];
		uv = bsc_pkg::RST_VBAND[15:0];
		ll = ln >= lt;
		bl = bs >= lt;
		cm = ll && bl && an < bsc_pkg::RST_STAGE1[15:0]
			&& (!ctrl_m[8] || (ln > uv && bs > uv))
			&& (!ctrl_m[9] || (ln < bsc_pkg::RST_VBAND[31:16] && bs < bsc_pkg::RST_VBAND[31:16]))
			&& (!ctrl_m[10] || (ln >= bs ? ln - bs : bs - ln) < bsc_pkg::RST_DIFF[15:0]);
		c1 = ctrl_m[0] && e1 && ctrl_m[1] && cm
			&& (!ctrl_m[11] || sl < bsc_pkg::RST_STAGE1[31:16]);
		c2 = ctrl_m[0] && e2 && ctrl_m[2] && cm && an < prev_an
			&& (!ctrl_m[13] || sl < bsc_pkg::RST_STAGE2[31:16]);
		// hold counts run in every mode, as the stages count whenever their condition holds
		h1 = c1 ? h1 + 1 : 0;
		h2 = c2 ? h2 + 1 : 0;
		if (ctrl_m[0]) begin
			q_flg.push_back({1'b0, es && ctrl_m[3] && ll && bl && an > bsc_pkg::RST_DIFF[31:16],
				c2 && (!ctrl_m[14] || h2 >= tmr), c1 && (!ctrl_m[12] || h1 >= tmr),
				bs < bsc_pkg::RST_LEVEL[31:16], bl, ln < bsc_pkg::RST_LEVEL[31:16], ll});
			prev_an = an;
		end else q_flg.push_back(8'h80);
		mag_in <= mg; ang_in <= ag; chk_in <= c; slip_in <= sl;
		u1 <= e1; u2 <= e2; us <= es; go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
	endtask

	// ==========================================================
	// result monitor
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && q_apb.size() > 0) begin
			x = q_apb.pop_front();
			if (!x[33]) `CHK(prdata, x[32:1])
			`CHK(pslverr, x[0])
		end
		if (upd_seen && q_flg.size() > 0) begin
			y = q_flg.pop_front();
			`CHK(flags[3:0], y[3:0])
			`CHK(flags[7:4], y[7:4])
		end
		upd_seen <= meas_update;
	end

	initial begin
		{psel, penable, pwrite, go, u1, u2, us, upd_seen} = '0;
		{paddr, pwdata, mag_in, ang_in, chk_in, slip_in} = '0;
		lfsr = 32'd76715; prev_an = '0; ctrl_m = bsc_pkg::RST_CTRL;
		tmr = bsc_pkg::RST_TIMER[15:0]; h1 = 0; h2 = 0;
		n_errors = 0; n_tests = 0; presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 8; i++) apb(offs[i], 1'b0, '0, rsts[i], 1'b0);
		apb(8'h28, 1'b0, '0, '0, 1'b1);
		apb(8'h28, 1'b1, '1, '0, 1'b1);
		apb(bsc_pkg::OFF_FLAGS, 1'b1, '1, '0, 1'b1);
		apb(bsc_pkg::OFF_FLAGS, 1'b0, '0, '0, 1'b0);
		for (i = 0; i < 4; i++) upd(1'b1, bnd[i]);
		// every side and check input choice, codes 6 and 7 included
		for (i = 0; i < 16; i++) begin
			ctrl_m = (bsc_pkg::RST_CTRL & ~32'hF0) | 32'(i << 4);
			apb(bsc_pkg::OFF_CTRL, 1'b1, ctrl_m, '0, 1'b0);
			repeat (6) upd(1'b0, '0);
		end
		// all voltage blocks and both slip controls, hold of two updates
		tmr = 16'h0002;
		apb(bsc_pkg::OFF_TIMER, 1'b1, {tmr, tmr}, '0, 1'b0);
		ctrl_m = bsc_pkg::RST_CTRL | 32'h7F00;
		apb(bsc_pkg::OFF_CTRL, 1'b1, ctrl_m, '0, 1'b0);
		repeat (12) upd(1'b1, 16'h0300);
		repeat (4) upd(1'b1, 16'h0600);
		ctrl_m = bsc_pkg::RST_CTRL & ~32'hE;
		apb(bsc_pkg::OFF_CTRL, 1'b1, ctrl_m, '0, 1'b0);
		repeat (4) upd(1'b0, '0);
		apb(bsc_pkg::OFF_IRQ_STAT, 1'b1, '1, '0, 1'b0);
		ctrl_m = bsc_pkg::RST_CTRL & ~32'h1;
		apb(bsc_pkg::OFF_CTRL, 1'b1, ctrl_m, '0, 1'b0);
		apb(bsc_pkg::OFF_FLAGS, 1'b0, '0, 32'h80, 1'b0);
		apb(bsc_pkg::OFF_IRQ_STAT, 1'b0, '0, 32'h80, 1'b0);
		`CHK(irq, 1'b0)
		apb(bsc_pkg::OFF_IRQ_MASK, 1'b1, 32'h80, '0, 1'b0);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b1)
		upd(1'b0, '0);
		apb(bsc_pkg::OFF_IRQ_STAT, 1'b1, 32'h80, '0, 1'b0);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b0)
		apb(bsc_pkg::OFF_IRQ_STAT, 1'b0, '0, '0, 1'b0);
		ctrl_m = bsc_pkg::RST_CTRL;
		apb(bsc_pkg::OFF_CTRL, 1'b1, ctrl_m, '0, 1'b0);
		apb(bsc_pkg::OFF_FLAGS, 1'b0, '0, '0, 1'b0);
		repeat (4) @(posedge pclk);
		tally_and_finish();
	end
endmodule
